// ===== hdl/seq_pkg.sv
// Package for the DC-bus supply startup sequencer.
// Assumes a single 100 MHz system clock and an Avalon-MM register master.
package seq_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_HZ          = 100_000_000; // System clock rate.
  localparam int unsigned CHARGE_MS       = 2400;        // Bus charge time.
  localparam int unsigned RELAY_MS        = 1000;        // Relay close time.
  localparam int unsigned PRECHARGE_MS    = CHARGE_MS + RELAY_MS;
  localparam int unsigned PRECHARGE_CYC   = PRECHARGE_MS * (CLK_HZ / 1000);
  localparam int unsigned BOOST_PCT       = 5;           // Bus raise in start.
  localparam int unsigned BOOST_US        = 1000;        // Raise ramp time.
  localparam int unsigned BOOST_CYC       = BOOST_US * (CLK_HZ / 1_000_000);

  // ==========================================================================
  // Register map (byte addresses, word index in address[5:2])
  // ==========================================================================
  localparam logic [7:0] ADDR_CTRL   = 8'h00; // Config and commands.
  localparam logic [7:0] ADDR_STATUS = 8'h04; // Live status bits.
  localparam logic [7:0] ADDR_IRQ    = 8'h08; // Sticky events, W1C.
  localparam logic [7:0] ADDR_MASK   = 8'h0C; // Interrupt mask.
  localparam logic [7:0] ADDR_INPCFG = 8'h10; // Input assignment and levels.

  // CTRL fields.
  localparam int CTRL_AUTO   = 0; // 1 = automatic startup method.
  localparam int CTRL_INIT   = 1; // Initialization complete flag.
  localparam int CMD_SON     = 8; // Servo-on command pulse.
  localparam int CMD_SOFF    = 9; // Servo-off command pulse.
  localparam int CMD_SD      = 10; // Axis shutdown command pulse.
  localparam int CMD_SDR     = 11; // Axis shutdown reset command pulse.
  localparam logic CTRL_AUTO_RST = 1'b0; // Enable-request is the default.

  // INPCFG fields: assignment in [3:0], required level in [11:8].
  localparam int         NUM_DIN        = 4;
  localparam logic [3:0] INP_ASSIGN_RST = 4'h1; // Enable on input 1.
  localparam logic [3:0] INP_LEVEL_RST  = 4'hF; // Active high required.
  localparam int         LEVEL_LSB      = 8;

  // ==========================================================================
  // Sequencer states, one-hot
  // ==========================================================================
  typedef enum logic [7:0] {
    ST_INIT      = 8'h01,
    ST_PRECHARGE = 8'h02,
    ST_INHIBIT   = 8'h04,
    ST_STOPPED   = 8'h08,
    ST_STARTING  = 8'h10,
    ST_RUNNING   = 8'h20,
    ST_SHUTDOWN  = 8'h40
  } seq_state_e;

  // Status bit layout of the STATUS register; IRQ and MASK use the event bits.
  typedef struct packed {
    logic tracking_ready_status;       // Bit 4.
    logic power_stage_enabled_status;  // Bit 3.
    logic bus_unload_status;           // Bit 2.
    logic bus_charged_status;          // Bit 1.
    logic contactor_enable_output;     // Bit 0.
  } seq_status_s;

  // Events that latch into the sticky register.
  localparam int EV_CHARGED  = 0; // Precharge finished.
  localparam int EV_RUNNING  = 1; // Running reached.
  localparam int EV_STOPPED  = 2; // Stopped reached.
  localparam int EV_SHUTDOWN = 3; // Shutdown entered.
  localparam int NUM_EV      = 4;

endpackage

// ===== hdl/bus_supply_startup_sequencer.sv
// Startup and shutdown sequencer for a regenerative DC-bus supply.
// Assumes clk_sys at 100 MHz, an Avalon-MM master, raw digital input pins.
//
// Summary of operation
// [R01] Precharge only after initialization completes.
// [R02] Startup method configurable, enable-request default.
// [R03] Close line contactor when precharge begins.
// [R04] Precharge lasts 3.4 seconds total.
// [R05] Raise bus charged, then go inhibited.
// [R06] Inactive configured inputs hold start inhibited.
// [R07] Enable permissive defaults to digital input 1.
// [R08] External 24V supplies the enable input.
// [R09] Leave inhibited when inputs unassigned or correct.
// [R10] Stopped shows charged high, unload low.
// [R11] Stopped motors only, no regeneration.
// [R12] Servo-on moves stopped to starting.
// [R13] Starting enables power stage, raises bus.
// [R14] Running sets tracking ready status.
// [R15] Automatic mode skips stopped and servo-on.
// [R16] Servo-off in running returns to stopped; the code ignores servo-off in automatic mode.
// [R17] Shutdown holds until shutdown reset command.
// [R18] Commands are pulses, ignored where meaningless.
// [R19] Current state readable, updated each transition.
`timescale 1ns/1ps
`default_nettype none

module bus_supply_startup_sequencer
  import seq_pkg::*;
#(
  parameter int unsigned PRECHARGE_CYCLES = PRECHARGE_CYC, // Precharge length.
  parameter int unsigned BOOST_CYCLES     = BOOST_CYC      // Bus raise time.
) (
  input  wire logic        clk_sys,          // System clock, 100 MHz.
  input  wire logic        rst,              // Async reset, active high.
  input  wire logic [7:0]  avs_address,      // Byte address.
  input  wire logic        avs_read,         // Read request.
  input  wire logic        avs_write,        // Write request.
  input  wire logic [31:0] avs_writedata,    // Write data.
  input  wire logic [3:0]  avs_byteenable,   // Byte lanes.
  output logic [31:0]      avs_readdata,     // Read data.
  output logic             avs_waitrequest,  // Stall until answer.
  input  wire logic [NUM_DIN-1:0] din_pins,  // Digital input connector.
  output logic             contactor_enable_output, // Line contactor drive.
  output logic             power_stage_on,   // Power transistor enable.
  output logic             regen_allowed,    // Regeneration permitted.
  output logic             bus_boost_req,    // Bus raise request.
  output logic             irq               // Level interrupt.
);

  // ==========================================================================
  // Registers and signals
  // ==========================================================================
  seq_state_e        state_r;           // Current sequencer state.
  seq_state_e        state_nxt;         // Next sequencer state.
  logic [31:0]       cnt_r;             // Shared state timer.
  logic              ctrl_auto_r;       // Startup method select.
  logic              ctrl_init_r;       // Initialization complete.
  logic [3:0]        cmd_r;             // One-cycle command pulses.
  logic [NUM_DIN-1:0] inp_assign_r;     // Inputs assigned to enable.
  logic [NUM_DIN-1:0] inp_level_r;      // Required input levels.
  logic [NUM_DIN-1:0] din_meta_r;       // First synchroniser stage.
  logic [NUM_DIN-1:0] din_sync_r;       // Second synchroniser stage.
  seq_status_s       status_r;          // Live status bits.
  logic [NUM_EV-1:0] irq_stat_r;        // Sticky event bits.
  logic [NUM_EV-1:0] irq_mask_r;        // Interrupt mask.
  logic [NUM_EV-1:0] ev;                // Events this cycle.
  logic              inputs_ok;         // Permissive satisfied.
  logic              timer_done;        // Timer reached its limit.
  logic              acc;               // Bus access this cycle.
  logic              ack_r;             // Answer cycle flag.
  logic              wr_take;           // Write lands this cycle.
  logic [31:0]       ctrl_merged;       // CTRL word after lane merge.
  logic [31:0]       cfg_merged;        // Other words after lane merge.

  // Byte-masked merge of write data into an existing word.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================================================
  // Input synchroniser
  // ==========================================================================
  // Pins are asynchronous; two flops before anything reads them.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      din_meta_r <= '0;
      din_sync_r <= '0;
    end else begin
      din_meta_r <= din_pins;
      din_sync_r <= din_meta_r;
    end
  end

  // Every assigned input must show its configured level.
  assign inputs_ok = &(~inp_assign_r | ~(din_sync_r ^ inp_level_r)); // [R06] [R09]

  // ==========================================================================
  // Bus slave
  // ==========================================================================
  // One wait cycle: requests are answered on the second edge.
  assign acc = (avs_read || avs_write) && !ack_r;

  // Writes land only at the edge where waitrequest is sampled low.
  assign wr_take     = ack_r && avs_write;
  assign ctrl_merged = merge({30'h0, ctrl_init_r, ctrl_auto_r},
                             avs_writedata, avs_byteenable);
  assign cfg_merged  = merge(32'h0, avs_writedata, avs_byteenable);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= acc;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !acc;
    end
  end

  // Read mux; unmapped addresses read zero.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (acc && avs_read) begin
      case (avs_address)
        ADDR_CTRL:   avs_readdata <= {30'h0, ctrl_init_r, ctrl_auto_r};
        ADDR_STATUS: avs_readdata <= {16'h0, state_r, 3'h0, status_r}; // [R19]
        ADDR_IRQ:    avs_readdata <= {28'h0, irq_stat_r};
        ADDR_MASK:   avs_readdata <= {28'h0, irq_mask_r};
        ADDR_INPCFG: avs_readdata <= {20'h0, inp_level_r, 4'h0, inp_assign_r};
        default:     avs_readdata <= '0;
      endcase
    end
  end

  // Configuration writes take effect on the answer edge.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_auto_r  <= CTRL_AUTO_RST; // [R02]
      ctrl_init_r  <= 1'b0;
      inp_assign_r <= INP_ASSIGN_RST; // [R07]
      inp_level_r  <= INP_LEVEL_RST;
      irq_mask_r   <= '0;
    end else if (wr_take) begin
      case (avs_address)
        ADDR_CTRL: begin
          ctrl_auto_r <= ctrl_merged[CTRL_AUTO];
          ctrl_init_r <= ctrl_merged[CTRL_INIT];
        end
        ADDR_MASK: begin
          irq_mask_r <= cfg_merged[NUM_EV-1:0];
        end
        ADDR_INPCFG: begin
          inp_assign_r <= cfg_merged[NUM_DIN-1:0];
          inp_level_r  <= cfg_merged[LEVEL_LSB +: NUM_DIN];
        end
        default: begin
        end
      endcase
    end
  end

  // Command bits in CTRL are self-clearing one-cycle pulses.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_r <= '0;
    end else if (wr_take && avs_address == ADDR_CTRL
                 && avs_byteenable[1]) begin
      cmd_r <= avs_writedata[CMD_SDR:CMD_SON]; // [R18]
    end else begin
      cmd_r <= '0;
    end
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  assign timer_done = (state_r == ST_PRECHARGE)
                      ? (cnt_r >= PRECHARGE_CYCLES - 1)
                      : (cnt_r >= BOOST_CYCLES - 1);

  // Next-state logic; commands outside their states fall through unused.
  always_comb begin
    state_nxt = state_r;
    if (cmd_r[CMD_SD - CMD_SON] && state_r != ST_INIT) begin
      state_nxt = ST_SHUTDOWN; // [R17]
    end else begin
      case (state_r)
        ST_INIT: begin
          if (ctrl_init_r) begin
            state_nxt = ST_PRECHARGE; // [R01]
          end
        end
        ST_PRECHARGE: begin
          if (timer_done) begin
            state_nxt = ST_INHIBIT; // [R04] [R05]
          end
        end
        ST_INHIBIT: begin
          if (inputs_ok) begin
            // Automatic startup bypasses stopped.
            state_nxt = ctrl_auto_r ? ST_STARTING : ST_STOPPED; // [R09] [R15]
          end
        end
        ST_STOPPED: begin
          if (!inputs_ok) begin
            state_nxt = ST_INHIBIT; // [R06]
          end else if (cmd_r[CMD_SON - CMD_SON]) begin
            state_nxt = ST_STARTING; // [R12]
          end
        end
        ST_STARTING: begin
          if (!inputs_ok) begin
            state_nxt = ST_INHIBIT; // [R06]
          end else if (timer_done) begin
            state_nxt = ST_RUNNING; // [R13]
          end
        end
        ST_RUNNING: begin
          if (!inputs_ok) begin
            state_nxt = ST_INHIBIT; // [R06]
          end else if (cmd_r[CMD_SOFF - CMD_SON] && !ctrl_auto_r) begin
            state_nxt = ST_STOPPED; // [R16]
          end
        end
        ST_SHUTDOWN: begin
          if (cmd_r[CMD_SDR - CMD_SON]) begin
            state_nxt = ST_PRECHARGE; // [R17]
          end
        end
        default: state_nxt = ST_INIT;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= ST_INIT;
    end else begin
      state_r <= state_nxt; // [R19]
    end
  end

  // Timer restarts on every state change.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      cnt_r <= '0;
    end else if (!timer_done) begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  // ==========================================================================
  // Outputs and status
  // ==========================================================================
  // All drive and status outputs register from the next state so they track the state.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status_r                <= '0;
      contactor_enable_output <= 1'b0;
      power_stage_on          <= 1'b0;
      regen_allowed           <= 1'b0;
      bus_boost_req           <= 1'b0;
    end else begin
      contactor_enable_output <= state_nxt != ST_INIT
                                 && state_nxt != ST_SHUTDOWN; // [R03]
      status_r.contactor_enable_output <= state_nxt != ST_INIT
                                 && state_nxt != ST_SHUTDOWN;
      status_r.bus_charged_status <= state_nxt inside
          {ST_INHIBIT, ST_STOPPED, ST_STARTING, ST_RUNNING}; // [R05] [R10]
      status_r.bus_unload_status  <= state_nxt == ST_SHUTDOWN; // [R10]
      status_r.power_stage_enabled_status <= state_nxt inside
          {ST_STARTING, ST_RUNNING}; // [R13]
      power_stage_on <= state_nxt inside {ST_STARTING, ST_RUNNING}; // [R13]
      bus_boost_req  <= state_nxt inside {ST_STARTING, ST_RUNNING}; // [R13]
      status_r.tracking_ready_status <= state_nxt == ST_RUNNING; // [R14]
      regen_allowed  <= state_nxt == ST_RUNNING; // [R11]
    end
  end

  // ==========================================================================
  // Interrupts
  // ==========================================================================
  // One process drives every event bit, so the vector has a single driver.
  always_comb begin
    ev               = '0;
    ev[EV_CHARGED]   = state_r == ST_PRECHARGE && state_nxt == ST_INHIBIT;
    ev[EV_RUNNING]   = state_r != ST_RUNNING && state_nxt == ST_RUNNING;
    ev[EV_STOPPED]   = state_r != ST_STOPPED && state_nxt == ST_STOPPED;
    ev[EV_SHUTDOWN]  = state_r != ST_SHUTDOWN && state_nxt == ST_SHUTDOWN;
  end

  // Write one to clear; a new event in the same cycle wins.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_stat_r <= '0;
    end else if (wr_take && avs_address == ADDR_IRQ
                 && avs_byteenable[0]) begin
      irq_stat_r <= (irq_stat_r & ~avs_writedata[NUM_EV-1:0]) | ev;
    end else begin
      irq_stat_r <= irq_stat_r | ev;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_stat_r | ev) & irq_mask_r);
    end
  end

endmodule

`default_nettype wire

// ===== bench/seq_sva.sv
// Checker for the DC-bus supply startup sequencer, port relations only.
// Assumes one clock domain, clk_sys, with rst as its async reset.
`timescale 1ns/1ps
`default_nettype none

module seq_sva (
  input wire logic clk_sys,                 // System clock.
  input wire logic rst,                     // Async reset, active high.
  input wire logic avs_read,                // Read request.
  input wire logic avs_write,               // Write request.
  input wire logic avs_waitrequest,         // Bus stall.
  input wire logic contactor_enable_output, // Line contactor drive.
  input wire logic power_stage_on,          // Power transistor enable.
  input wire logic regen_allowed,           // Regeneration permitted.
  input wire logic bus_boost_req            // Bus raise request.
);
  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  no_regen_idle_a: assert property (regen_allowed |-> power_stage_on)
    else $error("regeneration allowed with power stage off");
  boost_with_stage_a: assert property (
    power_stage_on == bus_boost_req)
    else $error("bus raise request differs from power stage");
  run_needs_line_a: assert property (
    regen_allowed |-> contactor_enable_output)
    else $error("running without line contactor");
  stage_needs_line_a: assert property (
    power_stage_on |-> contactor_enable_output)
    else $error("power stage on without line contactor");
  precharge_hold_a: assert property (
    $rose(contactor_enable_output) |-> !power_stage_on [*8])
    else $error("power stage on during precharge");
  start_first_a: assert property (
    $rose(power_stage_on) |-> !regen_allowed ##1 !regen_allowed)
    else $error("running entered without starting");
  shutdown_off_a: assert property (
    $fell(contactor_enable_output) |-> !power_stage_on && !regen_allowed)
    else $error("outputs left on after shutdown");
  bus_answer_a: assert property (
    (avs_read || avs_write) |-> ##[0:2] !avs_waitrequest)
    else $error("bus request not answered in time");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  // Main scenarios reached.
  run_seen_c: cover property ($rose(regen_allowed));
  stop_seen_c: cover property ($fell(regen_allowed) && contactor_enable_output);
  shut_seen_c: cover property ($fell(contactor_enable_output));
endmodule

bind bus_supply_startup_sequencer seq_sva i_seq_sva (
  .clk_sys(clk_sys), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest),
  .contactor_enable_output(contactor_enable_output),
  .power_stage_on(power_stage_on), .regen_allowed(regen_allowed),
  .bus_boost_req(bus_boost_req));
`default_nettype wire

// ===== bench/permissive_model.sv
// Model of the external enable permissive circuit on the input connector.
// Assumes an open circuit leaves the input pulled low.
`timescale 1ns/1ps
`default_nettype none

module permissive_model (
  input  wire logic       closed,  // Permissive circuit closed.
  output logic      [3:0] din      // Digital input levels.
);
  // Closing applies the supply to input 1; other inputs stay pulled low.
  assign din = {3'b000, closed};
endmodule
`default_nettype wire

// ===== bench/tb_bus_supply_startup_sequencer.sv
// Testbench for the startup sequencer, driven over Avalon-MM.
// Assumes shortened precharge and bus raise counts set below.
`timescale 1ns/1ps
`default_nettype none

module tb_bus_supply_startup_sequencer;
  import seq_pkg::*;
  localparam int PRE = 50; // Shortened precharge length.
  logic        clk_sys = 1'b0;   // System clock.
  logic        rst     = 1'b1;   // Reset.
  logic [7:0]  avs_address = '0; // Bus address.
  logic        avs_read = 1'b0;  // Read request.
  logic        avs_write = 1'b0; // Write request.
  logic [31:0] avs_writedata = '0; // Write data.
  logic [31:0] avs_readdata, rd; // Read data and last taken value.
  logic        avs_waitrequest, contactor, power_stage_on, regen_allowed, irq;
  logic        bus_boost_req;    // Bus raise request.
  logic [3:0]  din_pins;         // Input pins.
  logic        closed = 1'b0;    // Permissive state.
  int          num_errors = 0, n_compared = 0, cyc = 0;

  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  permissive_model i_permissive_model (.closed(closed), .din(din_pins));
  bus_supply_startup_sequencer #(.PRECHARGE_CYCLES(PRE), .BOOST_CYCLES(10))
    i_bus_supply_startup_sequencer (.clk_sys(clk_sys), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .din_pins(din_pins), .contactor_enable_output(contactor),
    .power_stage_on(power_stage_on), .regen_allowed(regen_allowed),
    .bus_boost_req(bus_boost_req), .irq(irq));

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch.
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask

  // One bus transfer, held until waitrequest is sampled low.
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 40) begin
      chk("bus answer", 32'h0, 32'h1);
      give_verdict();
    end
  endtask

  // Polls the state field until it shows the wanted state.
  task automatic wait_state(input logic [7:0] st);
    int n;
    n = 0;
    do begin
      xfer(1'b0, ADDR_STATUS, '0);
      n++;
    end while (rd[15:8] !== st && n < 100);
    chk("state", {24'h0, st}, {24'h0, rd[15:8]});
    if (n >= 100) give_verdict();
  endtask

  task automatic t_defaults;
    xfer(1'b0, ADDR_CTRL, '0);
    chk("ctrl", 32'h0, rd);
    xfer(1'b0, ADDR_INPCFG, '0);
    chk("inpcfg", 32'h00000F01, rd);
    xfer(1'b0, ADDR_STATUS, '0);
    chk("status", 32'h00000100, rd);
    xfer(1'b0, 8'h14, '0);
    chk("unmapped", 32'h0, rd);
    $display("test defaults done");
  endtask

  task automatic t_precharge;
    int   t0;
    logic in_time;
    xfer(1'b1, ADDR_MASK, 32'h1);
    xfer(1'b1, ADDR_CTRL, 32'h2);
    t0 = cyc;
    xfer(1'b0, ADDR_STATUS, '0);
    chk("precharge", 32'h0201, rd);
    wait_state(8'h04);
    in_time = (cyc - t0 >= PRE - 2) && (cyc - t0 <= PRE + 8);
    chk("precharge time", 32'h1, {31'h0, in_time});
    xfer(1'b1, ADDR_CTRL, 32'h102);
    xfer(1'b0, ADDR_STATUS, '0);
    chk("inhibit", 32'h0403, rd);
    chk("irq set", 32'h1, {31'h0, irq});
    xfer(1'b1, ADDR_IRQ, 32'h1);
    xfer(1'b0, ADDR_IRQ, '0);
    chk("irq clear", 32'h0, rd);
    chk("irq low", 32'h0, {31'h0, irq});
    $display("test precharge done");
  endtask

  task automatic t_run;
    closed <= 1'b1;
    wait_state(8'h08);
    xfer(1'b0, ADDR_STATUS, '0);
    chk("stopped", 32'h0803, rd);
    chk("stop regen", 32'h0, {31'h0, regen_allowed});
    chk("masked irq", 32'h0, {31'h0, irq});
    xfer(1'b1, ADDR_CTRL, 32'h102);
    xfer(1'b0, ADDR_STATUS, '0);
    chk("starting", 32'h100B, rd);
    chk("stage", 32'h3, {30'h0, power_stage_on, bus_boost_req});
    wait_state(8'h20);
    xfer(1'b0, ADDR_STATUS, '0);
    chk("running", 32'h201B, rd);
    chk("run regen", 32'h1, {31'h0, regen_allowed});
    xfer(1'b1, ADDR_CTRL, 32'h202);
    wait_state(8'h08);
    $display("test run done");
  endtask

  task automatic t_shutdown;
    xfer(1'b1, ADDR_CTRL, 32'h402);
    wait_state(8'h40);
    chk("unload", 32'h1, {31'h0, rd[2]});
    chk("contactor", 32'h0, {31'h0, contactor});
    chk("stage off", 32'h0, {30'h0, power_stage_on, bus_boost_req});
    xfer(1'b1, ADDR_CTRL, 32'h103);
    xfer(1'b0, ADDR_STATUS, '0);
    chk("held", 32'h40, {24'h0, rd[15:8]});
    xfer(1'b1, ADDR_CTRL, 32'h803);
    wait_state(8'h02);
    $display("test shutdown done");
  endtask

  task automatic t_auto;
    xfer(1'b1, ADDR_IRQ, 32'hF);
    wait_state(8'h20);
    xfer(1'b0, ADDR_IRQ, '0);
    chk("auto events", 32'h3, rd);
    xfer(1'b1, ADDR_INPCFG, 32'h0F00);
    closed <= 1'b0;
    repeat (8) @(posedge clk_sys);
    xfer(1'b0, ADDR_STATUS, '0);
    chk("unassigned", 32'h20, {24'h0, rd[15:8]});
    $display("test auto done");
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_defaults();
    t_precharge();
    t_run();
    t_shutdown();
    t_auto();
    give_verdict();
  end
endmodule
`default_nettype wire
